// *** core/flash_host_regs.vh ***
// timing, command and address constants for the parallel flash host controller
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// clock rate in MHz (period 4 ns)
`define CLK_MHZ 32'd250
// least times in ns, rounded up to whole cycles where used
`define T_WP_NS 32'd90
`define T_WPH_NS 32'd90
`define T_AH_NS 32'd50
`define T_ACC_NS 32'd55
`define T_OEHP_NS 32'd150
// longest internal operation times
`define T_BP_US 32'd50
`define T_EC_S 32'd10
`define CLK_HZ 32'd250_000_000

// user operation codes
`define OP_READ 3'h0
`define OP_PROGRAM 3'h1
`define OP_CHIP_ERASE 3'h2
`define OP_MAIN_ERASE 3'h3
`define OP_ID_ENTRY 3'h4
`define OP_ID_EXIT 3'h5
`define OP_LOCKOUT 3'h6

// command sequence addresses and bytes
`define SEQ_ADDR_A 15'h5555
`define SEQ_ADDR_B 15'h2aaa
`define CMD_UNLOCK1 8'haa
`define CMD_UNLOCK2 8'h55
`define CMD_ERASE_SETUP 8'h80
`define CMD_PROGRAM 8'ha0
`define CMD_ID_ENTRY 8'h90
`define CMD_ID_EXIT 8'hf0
`define CMD_LOCKOUT 8'h40
`define CMD_CHIP_ERASE 8'h10
`define CMD_MAIN_ERASE 8'h30

// boot block word range and toggle bit position
`define BOOT_LO 15'h0000
`define BOOT_HI 15'h1fff
`define TOGGLE_BIT 6

`endif

// *** core/flash_bus_cycle.v ***
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.vh"

module flash_bus_cycle (
  // clock and reset
  input wire clk,
  input wire resetn,
  // request from the sequencer
  input wire start,
  input wire is_read,
  input wire [14:0] req_addr,
  input wire [15:0] req_data,
  output reg done_q,
  output reg [15:0] rdata_q,
  // flash pins
  output reg ce_n_q,
  output reg oe_n_q,
  output reg we_n_q,
  output reg [14:0] addr_q,
  output reg [15:0] dq_out_q,
  output reg dq_oe_q,
  input wire [15:0] dq_in
);

  // cycle counts worked out at full width, then cut to the counter width
  localparam [31:0] WP_FULL = (`T_WP_NS * `CLK_MHZ + 32'd999) / 32'd1000;
  localparam [31:0] WPH_FULL = (`T_WPH_NS * `CLK_MHZ + 32'd999) / 32'd1000;
  localparam [31:0] AH_FULL = (`T_AH_NS * `CLK_MHZ + 32'd999) / 32'd1000;
  // two extra cycles cover the input synchroniser
  localparam [31:0] RD_FULL = (`T_ACC_NS * `CLK_MHZ + 32'd999) / 32'd1000 + 32'd2;
  localparam [31:0] OEHP_FULL = (`T_OEHP_NS * `CLK_MHZ + 32'd999) / 32'd1000;
  localparam [7:0] WP_CYC = WP_FULL[7:0];
  localparam [7:0] WPH_CYC = WPH_FULL[7:0];
  localparam [7:0] AH_CYC = AH_FULL[7:0];
  localparam [7:0] RD_CYC = RD_FULL[7:0];
  localparam [7:0] OEHP_CYC = OEHP_FULL[7:0];
  localparam [7:0] WHOLD_CYC = (WPH_CYC > AH_CYC) ? WPH_CYC : AH_CYC;

  localparam [1:0] C_IDLE = 2'd0;
  localparam [1:0] C_STROBE = 2'd1;
  localparam [1:0] C_RECOVER = 2'd2;

  reg [1:0] state_q;
  reg [7:0] cnt_q;
  reg rd_q;
  reg [15:0] sync1_q;
  reg [15:0] sync2_q;

  // two-stage synchroniser on the data pins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= dq_in;
      sync2_q <= sync1_q;
    end
  end

  // strobe sequencing; output enable stays high on writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= C_IDLE;
      cnt_q <= 8'h00;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= 15'h0000;
      dq_out_q <= 16'h0000;
      dq_oe_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        C_IDLE: begin
          if (start) begin
            rd_q <= is_read;
            addr_q <= req_addr;
            dq_out_q <= req_data;
            dq_oe_q <= ~is_read;
            ce_n_q <= 1'b0;
            oe_n_q <= ~is_read;
            we_n_q <= is_read;
            cnt_q <= is_read ? RD_CYC : WP_CYC;
            state_q <= C_STROBE;
          end
        end
        C_STROBE: begin
          if (cnt_q == 8'h01) begin
            // both strobes rise together; address and data held after
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            if (rd_q) begin
              rdata_q <= sync2_q;
            end
            // read gap keeps the toggling strobes high long enough
            cnt_q <= rd_q ? OEHP_CYC : WHOLD_CYC;
            state_q <= C_RECOVER;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        C_RECOVER: begin
          if (cnt_q == 8'h01) begin
            dq_oe_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= C_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= C_IDLE;
        end
      endcase
    end
  end

endmodule // flash_bus_cycle
`default_nettype wire

// *** core/flash_host.v ***
// host-side command sequencer and toggle-bit poller for a 16-bit parallel flash
//
// Overview of operation
// - output enable high throughout every write
// - chip erase sequence ends with 10H
// - main block erase sequence ends 30H
// - completion only when bit 6 stops changing
// - poll reads keep one fixed address
// - toggling strobe meets minimum high pulse
// - command byte on low data, address 14:0
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.vh"

module flash_host #(
  parameter [31:0] PROG_TIMEOUT_CYC = `T_BP_US * `CLK_MHZ,
  parameter [31:0] ERASE_TIMEOUT_CYC = `T_EC_S * `CLK_HZ
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // user command port
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [14:0] cmd_addr,
  input wire [15:0] cmd_data,
  output reg cmd_ready_q,
  // user answer port
  output reg rsp_valid_q,
  output reg rsp_err_q,
  output reg [15:0] rsp_data_q,
  output reg lockout_q,
  // flash pins
  output wire ce_n,
  output wire oe_n,
  output wire we_n,
  output wire [14:0] flash_addr,
  output wire [15:0] dq_out,
  output wire dq_oe,
  input wire [15:0] dq_in
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_WWAIT = 3'd1;
  localparam [2:0] S_RWAIT = 3'd2;
  localparam [2:0] S_PWAIT = 3'd3;

  reg [2:0] state_q;
  reg [2:0] op_q;
  reg [14:0] addr_q;
  reg [15:0] data_q;
  reg [2:0] step_q;
  reg first_q;
  reg prev_q;
  reg [31:0] tmo_q;
  reg start_q;
  reg brd_q;
  reg [14:0] baddr_q;
  reg [15:0] bdata_q;
  wire bus_done;
  wire [15:0] bus_rdata;

  // number of writes in each command sequence
  function [2:0] seq_len;
    input [2:0] op;
    begin
      case (op)
        `OP_PROGRAM: seq_len = 3'd4;
        `OP_CHIP_ERASE: seq_len = 3'd6;
        `OP_MAIN_ERASE: seq_len = 3'd6;
        `OP_LOCKOUT: seq_len = 3'd6;
        default: seq_len = 3'd3;
      endcase
    end
  endfunction

  // address and command byte of one step; upper data byte sent as zero
  function [22:0] seq_word;
    input [2:0] op;
    input [2:0] idx;
    begin
      case (idx)
        3'd0: seq_word = {`SEQ_ADDR_A, `CMD_UNLOCK1};
        3'd1: seq_word = {`SEQ_ADDR_B, `CMD_UNLOCK2};
        3'd2: begin
          case (op)
            `OP_PROGRAM: seq_word = {`SEQ_ADDR_A, `CMD_PROGRAM};
            `OP_ID_ENTRY: seq_word = {`SEQ_ADDR_A, `CMD_ID_ENTRY};
            `OP_ID_EXIT: seq_word = {`SEQ_ADDR_A, `CMD_ID_EXIT};
            default: seq_word = {`SEQ_ADDR_A, `CMD_ERASE_SETUP};
          endcase
        end
        3'd3: seq_word = {`SEQ_ADDR_A, `CMD_UNLOCK1};
        3'd4: seq_word = {`SEQ_ADDR_B, `CMD_UNLOCK2};
        default: begin
          case (op)
            `OP_CHIP_ERASE: seq_word = {`SEQ_ADDR_A, `CMD_CHIP_ERASE};
            `OP_MAIN_ERASE: seq_word = {`SEQ_ADDR_A, `CMD_MAIN_ERASE};
            default: seq_word = {`SEQ_ADDR_A, `CMD_LOCKOUT};
          endcase
        end
      endcase
    end
  endfunction

  wire [22:0] next_word = seq_word(op_q, step_q + 3'd1);
  wire is_erase = (op_q == `OP_CHIP_ERASE) || (op_q == `OP_MAIN_ERASE);
  wire is_prog = (op_q == `OP_PROGRAM);
  wire [31:0] tmo_limit = is_prog ? PROG_TIMEOUT_CYC : ERASE_TIMEOUT_CYC;
  // a program aimed at a locked boot block is refused here, not sent
  wire boot_hit = (cmd_addr >= `BOOT_LO) && (cmd_addr <= `BOOT_HI);
  wire new_bit = bus_rdata[`TOGGLE_BIT];

  // sequencer: command writes, plain reads and toggle polling
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      op_q <= `OP_READ;
      addr_q <= 15'h0000;
      data_q <= 16'h0000;
      step_q <= 3'd0;
      first_q <= 1'b0;
      prev_q <= 1'b0;
      tmo_q <= 32'h0000_0000;
      start_q <= 1'b0;
      brd_q <= 1'b0;
      baddr_q <= 15'h0000;
      bdata_q <= 16'h0000;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_err_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      lockout_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            op_q <= cmd_op;
            addr_q <= cmd_addr;
            data_q <= cmd_data;
            step_q <= 3'd0;
            if (cmd_op == `OP_READ) begin
              // identification codes are read this way too
              start_q <= 1'b1;
              brd_q <= 1'b1;
              baddr_q <= cmd_addr;
              state_q <= S_RWAIT;
            end else if (cmd_op == `OP_PROGRAM && lockout_q && boot_hit) begin
              rsp_valid_q <= 1'b1;
              rsp_err_q <= 1'b1;
              rsp_data_q <= 16'h0000;
            end else if (cmd_op > `OP_LOCKOUT) begin
              rsp_valid_q <= 1'b1;
              rsp_err_q <= 1'b1;
              rsp_data_q <= 16'h0000;
            end else begin
              start_q <= 1'b1;
              brd_q <= 1'b0;
              baddr_q <= `SEQ_ADDR_A;
              bdata_q <= {8'h00, `CMD_UNLOCK1};
              state_q <= S_WWAIT;
            end
          end
        end
        S_WWAIT: begin
          if (bus_done) begin
            if (step_q + 3'd1 < seq_len(op_q)) begin
              step_q <= step_q + 3'd1;
              start_q <= 1'b1;
              brd_q <= 1'b0;
              if (is_prog && step_q == 3'd2) begin
                baddr_q <= addr_q;
                bdata_q <= data_q;
              end else begin
                baddr_q <= next_word[22:8];
                bdata_q <= {8'h00, next_word[7:0]};
              end
            end else if (is_prog || is_erase) begin
              // poll one fixed address: the target word, or word 0 on erase
              start_q <= 1'b1;
              brd_q <= 1'b1;
              baddr_q <= is_prog ? addr_q : 15'h0000;
              first_q <= 1'b1;
              tmo_q <= 32'h0000_0000;
              state_q <= S_PWAIT;
            end else begin
              if (op_q == `OP_LOCKOUT) begin
                lockout_q <= 1'b1;
              end
              rsp_valid_q <= 1'b1;
              rsp_err_q <= 1'b0;
              rsp_data_q <= 16'h0000;
              state_q <= S_IDLE;
            end
          end
        end
        S_RWAIT: begin
          if (bus_done) begin
            rsp_valid_q <= 1'b1;
            rsp_err_q <= 1'b0;
            rsp_data_q <= bus_rdata;
            state_q <= S_IDLE;
          end
        end
        S_PWAIT: begin
          // bounded wait for the internal operation
          if (tmo_q != 32'hffff_ffff) begin
            tmo_q <= tmo_q + 32'h0000_0001;
          end
          if (bus_done) begin
            // done only when two reads agree; start value is not trusted
            if (!first_q && new_bit == prev_q) begin
              rsp_valid_q <= 1'b1;
              rsp_err_q <= 1'b0;
              rsp_data_q <= bus_rdata;
              state_q <= S_IDLE;
            end else if (tmo_q >= tmo_limit) begin
              rsp_valid_q <= 1'b1;
              rsp_err_q <= 1'b1;
              rsp_data_q <= bus_rdata;
              state_q <= S_IDLE;
            end else begin
              prev_q <= new_bit;
              first_q <= 1'b0;
              start_q <= 1'b1; // same baddr_q kept
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // pin timing engine; each read pulses both strobes
  flash_bus_cycle u_cycle (
    .clk(clk),
    .resetn(resetn),
    .start(start_q),
    .is_read(brd_q),
    .req_addr(baddr_q),
    .req_data(bdata_q),
    .done_q(bus_done),
    .rdata_q(bus_rdata),
    .ce_n_q(ce_n),
    .oe_n_q(oe_n),
    .we_n_q(we_n),
    .addr_q(flash_addr),
    .dq_out_q(dq_out),
    .dq_oe_q(dq_oe),
    .dq_in(dq_in)
  );

endmodule // flash_host
`default_nettype wire

// *** verification/flash_host_monitor.sv ***
// port-level checks on the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_monitor (
  // clock and reset
  input wire clk,
  input wire resetn,
  // command side
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [14:0] cmd_addr,
  input wire cmd_ready_q,
  input wire rsp_valid_q,
  input wire rsp_err_q,
  input wire lockout_q,
  // flash pins
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [14:0] flash_addr,
  input wire dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] wlo_q, ohi_q;
  logic [14:0] radr_q;
  logic rsp_since_q;
  // strobe width counters; reset fills the gap count so the first read is legal
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wlo_q <= 8'h00;
      ohi_q <= 8'hff;
      radr_q <= 15'h0000;
      rsp_since_q <= 1'b1;
    end else begin
      wlo_q <= we_n ? 8'h00 : wlo_q + 8'h01;
      ohi_q <= !oe_n ? 8'h00 : (ohi_q == 8'hff ? ohi_q : ohi_q + 8'h01);
      if (!oe_n) radr_q <= flash_addr;
      rsp_since_q <= rsp_valid_q | (rsp_since_q & oe_n);
    end
  end
  sequence s_addr_hold;
    $stable(flash_addr) [*8];
  endsequence
  a_oe_high_write: assert property ((!we_n && !ce_n) |-> oe_n)
    else $error("output enable low during a write pulse");
  a_no_fight: assert property (!oe_n |-> !dq_oe && we_n)
    else $error("host drives data while reading");
  a_write_width: assert property ($rose(we_n) |-> wlo_q >= 8'd23)
    else $error("write pulse shorter than 23 cycles");
  a_addr_hold: assert property ($rose(we_n) |-> s_addr_hold)
    else $error("address changed too soon after a write");
  a_gate_gap: assert property ($fell(oe_n) |-> ohi_q >= 8'd38)
    else $error("output enable high pulse under 38 cycles");
  a_poll_addr: assert property ($fell(oe_n) && !rsp_since_q |-> flash_addr == radr_q)
    else $error("poll address moved between reads");
  a_refuse_fast: assert property (cmd_valid && cmd_ready_q && (cmd_op == 3'h7 ||
    (cmd_op == 3'h1 && lockout_q && cmd_addr <= 15'h1fff)) |=> rsp_valid_q && rsp_err_q && ce_n)
    else $error("refused request not answered at once");
  a_rsp_pulse: assert property (rsp_valid_q |=> !rsp_valid_q ##[0:2] cmd_ready_q)
    else $error("answer pulse or ready return wrong");
endmodule // flash_host_monitor
bind flash_host flash_host_monitor u_mon (.clk, .resetn, .cmd_valid, .cmd_op, .cmd_addr,
  .cmd_ready_q, .rsp_valid_q, .rsp_err_q, .lockout_q, .ce_n, .oe_n, .we_n, .flash_addr, .dq_oe);
`default_nettype wire

// *** verification/flash_device_model.sv ***
// behavioural flash device facing the host controller pins
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
  parameter [15:0] MFR_CODE = 16'h005a, // arbitrary value
  parameter [15:0] DEV_CODE = 16'h00c3 // arbitrary value
) (
  // strobes, address, data in
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [14:0] addr,
  input wire [15:0] din,
  // data out and long-busy control
  output logic [15:0] dq,
  input wire slow
);
  logic [15:0] mem [0:32767];
  logic [31:0] h;
  logic [15:0] q;
  logic idm, lock, tog;
  int busy;
  wire wr = ~ce_n & ~we_n;
  wire rd = ~ce_n & ~oe_n;
  // powers up out of identification mode, array erased
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'hffff;
    {h, q, idm, lock, tog, busy} = '0;
  end
  // a write is taken as its pulse ends; commands sit in the low byte only
  always @(negedge wr) begin
    if (h[7:0] == 8'ha0) begin
      if (!(lock && addr <= 15'h1fff)) mem[addr] = din;
      busy = slow ? 30 : 2;
      h = '0;
    end else begin
      h = {h[23:0], din[7:0]};
      if (h[31:24] == 8'h80 && (h[7:0] == 8'h10 || h[7:0] == 8'h30)) begin
        for (int i = 0; i < 32768; i++)
          if (i > 15'h1fff || (h[7:0] == 8'h10 && !lock)) mem[i] = 16'hffff;
        busy = slow ? 30 : 2;
      end
      if (h[31:24] == 8'h80 && h[7:0] == 8'h40) lock = 1'b1;
      if (h[7:0] == 8'h90) idm = 1'b1;
      if (h[7:0] == 8'hf0) idm = 1'b0;
    end
  end
  // each read while busy flips the status bit; delay lets the address land
  always @(posedge rd) begin
    #1;
    q = (idm && addr[14:1] == 14'h0000) ? (addr[0] ? DEV_CODE : MFR_CODE) : mem[addr];
    if (busy > 0) begin
      tog = ~tog;
      busy = busy - 1;
      q[6] = tog;
    end
  end
  // released lines show the inverse of the last word, not a held value
  assign dq = rd ? q : ~q;
endmodule // flash_device_model
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, resetn, cmd_valid, slow, err;
  logic [2:0] cmd_op;
  logic [14:0] cmd_addr;
  logic [15:0] cmd_data, got;
  wire cmd_ready_q, rsp_valid_q, rsp_err_q, lockout_q, ce_n, oe_n, we_n, dq_oe;
  wire [15:0] rsp_data_q, dq_out, dq_dev;
  wire [14:0] flash_addr;
  int mismatches, samples_checked;
  // the shared data pins: the host drives while dq_oe is set, the device at all other times
  wire [15:0] dq_pin = dq_oe ? dq_out : dq_dev;
  flash_host #(.PROG_TIMEOUT_CYC(32'h0000_0258), .ERASE_TIMEOUT_CYC(32'h0000_0258)) u_dut (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_err_q(rsp_err_q), .rsp_data_q(rsp_data_q), .lockout_q(lockout_q), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_pin));
  flash_device_model u_dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(flash_addr),
    .din(dq_pin), .dq(dq_dev), .slow(slow));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic results;
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one request held until taken, then wait for its answer and check the error flag
  task automatic t(input logic [2:0] o, input logic [14:0] a, input logic [15:0] d, input logic ee);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    while (cmd_ready_q !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid_q !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    // a request that never gets its answer counts as a mismatch
    chk({15'h0000, rsp_valid_q}, 16'h0001);
    got = rsp_data_q;
    err = rsp_err_q;
    chk({15'h0000, err}, {15'h0000, ee});
  endtask
  // program, the poll ends on the written word, read back
  task automatic sc_program;
    t(3'h1, 15'h0123, 16'ha5c3, 1'b0);
    chk(got, 16'ha5c3);
    t(3'h0, 15'h0123, 16'h0000, 1'b0);
    chk(got, 16'ha5c3);
  endtask
  // main erase spares the boot words, chip erase clears them
  task automatic sc_erase;
    t(3'h1, 15'h0010, 16'h1234, 1'b0);
    t(3'h1, 15'h4000, 16'h5678, 1'b0);
    t(3'h3, 15'h0000, 16'h0000, 1'b0);
    t(3'h0, 15'h0010, 16'h0000, 1'b0);
    chk(got, 16'h1234);
    t(3'h0, 15'h4000, 16'h0000, 1'b0);
    chk(got, 16'hffff);
    t(3'h2, 15'h0000, 16'h0000, 1'b0);
    t(3'h0, 15'h0010, 16'h0000, 1'b0);
    chk(got, 16'hffff);
  endtask
  // identification codes by the lowest address line, then back to array data
  task automatic sc_ident;
    t(3'h4, 15'h0000, 16'h0000, 1'b0);
    t(3'h0, 15'h0000, 16'h0000, 1'b0);
    chk(got, 16'h005a);
    t(3'h0, 15'h0001, 16'h0000, 1'b0);
    chk(got, 16'h00c3);
    t(3'h5, 15'h0000, 16'h0000, 1'b0);
    t(3'h0, 15'h0001, 16'h0000, 1'b0);
    chk(got, 16'hffff);
  endtask
  // lockout guards exactly the boot range; bad opcode refused too
  task automatic sc_lock;
    t(3'h6, 15'h0000, 16'h0000, 1'b0);
    chk({15'h0000, lockout_q}, 16'h0001);
    t(3'h1, 15'h1fff, 16'h0f0f, 1'b1);
    t(3'h1, 15'h2000, 16'h0f0f, 1'b0);
    t(3'h0, 15'h2000, 16'h0000, 1'b0);
    chk(got, 16'h0f0f);
    t(3'h7, 15'h0000, 16'h0000, 1'b1);
  endtask
  // a device that stays busy too long ends in an error answer
  task automatic sc_slow;
    slow = 1'b1;
    t(3'h1, 15'h3000, 16'h1111, 1'b1);
    slow = 1'b0;
  endtask
  // hang guard, well beyond the expected run of some 4.5k cycles
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    {resetn, cmd_valid, slow, cmd_op, cmd_addr, cmd_data} = '0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    sc_program();
    sc_erase();
    sc_ident();
    sc_lock();
    sc_slow();
    results();
  end
endmodule // tb_top
`default_nettype wire
